// ---- hw/soil_pkg.sv ----
package soil_pkg;
    // ----------------------------------------------------------------
    // word geometry
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam logic [16:0] BANK_WORDS = 17'h00064;
    localparam logic [15:0] MAX_QUANTITY = 16'h007D;
    localparam logic [15:0] PLC_BASE_STEP = 16'h0001;

    // ----------------------------------------------------------------
    // register offsets, zero-based protocol addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] OFS_PRODUCT_KIND_CODE = 16'h0000;
    localparam logic [15:0] OFS_MAP_REVISION = 16'h0001;
    localparam logic [15:0] OFS_FIRMWARE_REVISION = 16'h0002;
    localparam logic [15:0] OFS_PRODUCTION_YEAR = 16'h0003;
    localparam logic [15:0] OFS_UNIT_SERIAL = 16'h0004;
    localparam logic [15:0] OFS_BOARD_REVISION = 16'h0005;
    localparam logic [15:0] OFS_FACTORY_CAL_YEAR = 16'h0006;
    localparam logic [15:0] OFS_FACTORY_CAL_MONTH = 16'h0007;
    localparam logic [15:0] OFS_FACTORY_CAL_DAY = 16'h0008;
    localparam logic [15:0] OFS_CLEANLINESS_A = 16'h0014;
    localparam logic [15:0] OFS_LIGHT_LOSS_A = 16'h0015;
    localparam logic [15:0] OFS_CLEANLINESS_B = 16'h0018;
    localparam logic [15:0] OFS_LIGHT_LOSS_B = 16'h0019;
    localparam logic [15:0] OFS_LOCAL_CAL_READINESS = 16'h001A;
    localparam logic [15:0] OFS_LOCAL_CAL_COMPLETION = 16'h001B;
    localparam logic [15:0] OFS_INCLINE_LONG_AXIS = 16'h001C;
    localparam logic [15:0] OFS_INCLINE_SHORT_AXIS = 16'h001D;
    localparam logic [15:0] OFS_PANEL_HEAT_KELVIN = 16'h001F;
    localparam logic [15:0] OFS_SUPPLY_MILLIVOLTS = 16'h0020;
    localparam logic [15:0] OFS_RUN_STATE = 16'h0021;
    localparam logic [15:0] OFS_FAULT_WORD = 16'h0022;
    localparam logic [15:0] OFS_DUST_GAIN_BOTTOM = 16'h0024;

    // ----------------------------------------------------------------
    // value encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] INVALID_MARK = 16'h270F;
    localparam logic [15:0] CLEAN_MIN = 16'h01F4;
    localparam logic [15:0] CLEAN_MAX = 16'h03F2;
    localparam logic signed [15:0] LOSS_MIN = 16'shFFF6;
    localparam logic signed [15:0] LOSS_MAX = 16'sh01F4;
    localparam logic [15:0] KELVIN_OFFSET = 16'h0AAC;
    localparam logic [15:0] RESERVED_READ = 16'h0000;

    typedef enum logic [1:0] {
        SOIL_MODE_NORMAL = 2'h1,
        SOIL_MODE_SERVICE = 2'h2,
        SOIL_MODE_CALIB = 2'h3
    } soil_mode_e;

    // ----------------------------------------------------------------
    // exception codes of the serial protocol
    // ----------------------------------------------------------------
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY = 8'h06;
endpackage

// ---- hw/soil_rd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface soil_rd_if;
    logic [15:0] addr;
    logic measOk;
    logic [15:0] data;
    modport client (output addr, output measOk, input data);
    modport server (input addr, input measOk, output data);
endinterface
`default_nettype wire

// ---- hw/soil_word_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module soil_word_mux #(
    parameter logic [15:0] PRODUCT_KIND = 16'h0ABC,
    parameter logic [15:0] MAP_REV = 16'h0011,
    parameter logic [15:0] FW_REV = 16'h0022,
    parameter logic [15:0] BOARD_REV = 16'h0003,
    parameter logic [15:0] PROD_YEAR = 16'h0000,
    parameter logic [15:0] UNIT_SERIAL = 16'h0000,
    parameter logic [15:0] CAL_YEAR = 16'h07D0,
    parameter logic [15:0] CAL_MONTH = 16'h0001,
    parameter logic [15:0] CAL_DAY = 16'h0001
) (
    soil_rd_if.server rd,
    input wire logic [15:0] cleanA,
    input wire logic [15:0] lossA,
    input wire logic [15:0] cleanB,
    input wire logic [15:0] lossB,
    input wire logic [15:0] calReady,
    input wire logic [15:0] calDone,
    input wire logic [15:0] tiltLong,
    input wire logic [15:0] tiltShort,
    input wire logic [15:0] panelKelvin,
    input wire logic [15:0] supplyMv,
    input wire logic [15:0] runState,
    input wire logic [15:0] faultWord,
    input wire logic [15:0] dustGain
);
    // out-of-range readings collapse to the invalid marker
    function automatic logic [15:0] cleanChk(input logic [15:0] v);
        return (v < soil_pkg::CLEAN_MIN || v > soil_pkg::CLEAN_MAX) ? soil_pkg::INVALID_MARK : v;
    endfunction

    function automatic logic [15:0] lossChk(input logic [15:0] v);
        return ($signed(v) < soil_pkg::LOSS_MIN || $signed(v) > soil_pkg::LOSS_MAX) ? soil_pkg::INVALID_MARK : v;
    endfunction

    // cleanliness, light loss, cal readiness and completion words only in normal and service levels
    function automatic logic [15:0] gate(input logic [15:0] v);
        return rd.measOk ? v : soil_pkg::INVALID_MARK;
    endfunction

    always_comb begin
        case (rd.addr)
            soil_pkg::OFS_PRODUCT_KIND_CODE: rd.data = PRODUCT_KIND;
            soil_pkg::OFS_MAP_REVISION: rd.data = MAP_REV;
            soil_pkg::OFS_FIRMWARE_REVISION: rd.data = FW_REV;
            soil_pkg::OFS_PRODUCTION_YEAR: rd.data = PROD_YEAR;
            soil_pkg::OFS_UNIT_SERIAL: rd.data = UNIT_SERIAL;
            soil_pkg::OFS_BOARD_REVISION: rd.data = BOARD_REV;
            soil_pkg::OFS_FACTORY_CAL_YEAR: rd.data = CAL_YEAR;
            soil_pkg::OFS_FACTORY_CAL_MONTH: rd.data = CAL_MONTH;
            soil_pkg::OFS_FACTORY_CAL_DAY: rd.data = CAL_DAY;
            soil_pkg::OFS_CLEANLINESS_A: rd.data = gate(cleanChk(cleanA));
            soil_pkg::OFS_LIGHT_LOSS_A: rd.data = gate(lossChk(lossA));
            soil_pkg::OFS_CLEANLINESS_B: rd.data = gate(cleanChk(cleanB));
            soil_pkg::OFS_LIGHT_LOSS_B: rd.data = gate(lossChk(lossB));
            soil_pkg::OFS_LOCAL_CAL_READINESS: rd.data = gate(calReady);
            soil_pkg::OFS_LOCAL_CAL_COMPLETION: rd.data = gate(calDone);
            soil_pkg::OFS_INCLINE_LONG_AXIS: rd.data = tiltLong;
            soil_pkg::OFS_INCLINE_SHORT_AXIS: rd.data = tiltShort;
            soil_pkg::OFS_PANEL_HEAT_KELVIN: rd.data = panelKelvin;
            soil_pkg::OFS_SUPPLY_MILLIVOLTS: rd.data = supplyMv;
            soil_pkg::OFS_RUN_STATE: rd.data = runState;
            soil_pkg::OFS_FAULT_WORD: rd.data = faultWord;
            soil_pkg::OFS_DUST_GAIN_BOTTOM: rd.data = dustGain;
            // reserved gaps and the internal area read as zero
            default: rd.data = soil_pkg::RESERVED_READ;
        endcase
    end
endmodule // soil_word_mux
`default_nettype wire

// ---- hw/soil_regbank.sv ----
// What this block does
// - every word sixteen bits, read only
// - bank spans addresses zero through ninety-nine
// - addresses zero based; plc numbering one higher
// - address zero gives fixed product kind
// - addresses one, two give fixed revisions
// - addresses three, four give year, serial
// - addresses six to eight give calibration date
// - reserved gaps carry no content, read zero
// - address twenty cleanliness a, else invalid
// - address twenty-one signed light loss a
// - addresses twenty-four, twenty-five for sensor b
// - calibration readiness and completion words
// - signed tilt words in tenth degrees
// - panel temperature in tenth kelvin
// - supply voltage in millivolts
// - run state codes one, two, three
// - fault word, zero means no fault
// - dust gain updated on calibration completion
// - cleanliness, loss, cal readiness, completion only in normal, service
// - write attempts ignored, nothing stored
`timescale 1ns/1ps
`default_nettype none
module soil_regbank #(
    parameter logic [15:0] PRODUCT_KIND = 16'h0ABC, // arbitrary value
    parameter logic [15:0] MAP_REV = 16'h0011, // arbitrary value
    parameter logic [15:0] FW_REV = 16'h0022, // arbitrary value
    parameter logic [15:0] BOARD_REV = 16'h0003, // arbitrary value
    parameter logic [15:0] PROD_YEAR = 16'h0000,
    parameter logic [15:0] UNIT_SERIAL = 16'h0000,
    parameter logic [15:0] CAL_YEAR = 16'h07D0,
    parameter logic [15:0] CAL_MONTH = 16'h0001,
    parameter logic [15:0] CAL_DAY = 16'h0001,
    parameter logic [15:0] FACTORY_DUST_GAIN = 16'h03E8
) (
    input wire logic clk,
    input wire logic rst,
    // read request from the frame decoder
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [15:0] reqStart,
    input wire logic [15:0] reqCount,
    // answer words toward the frame encoder
    output logic rspValid,
    input wire logic rspReady,
    output logic [15:0] rspData,
    output logic [15:0] rspAddr,
    output logic rspLast,
    output logic rspExc,
    output logic [7:0] rspExcCode,
    // write attempts from the frame decoder
    input wire logic wrValid,
    input wire logic [15:0] wrAddr,
    input wire logic [15:0] wrData,
    output logic wrAck,
    // live values from the measurement logic
    input wire logic [1:0] opMode,
    input wire logic terminalMode,
    input wire logic [15:0] cleanA,
    input wire logic [15:0] lossA,
    input wire logic [15:0] cleanB,
    input wire logic [15:0] lossB,
    input wire logic [15:0] calReady,
    input wire logic [15:0] calDone,
    input wire logic [15:0] tiltLong,
    input wire logic [15:0] tiltShort,
    input wire logic [15:0] panelKelvin,
    input wire logic [15:0] supplyMv,
    input wire logic [15:0] faultWord,
    input wire logic calComplete,
    input wire logic [15:0] calGain
);
    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SOIL_IDLE = 4'h1,
        SOIL_LOAD = 4'h2,
        SOIL_SEND = 4'h4,
        SOIL_EXC = 4'h8
    } soil_state_e;

    soil_state_e state_q;
    soil_state_e state_d;
    logic [15:0] addr_q;
    logic [15:0] remain_q;
    logic [15:0] data_q;
    logic [15:0] rspAddr_q;
    logic last_q;
    logic [7:0] excCode_q;
    logic [15:0] dustGain_q;
    logic wrAck_q;
    logic [16:0] endAddr;
    logic [7:0] reqCheck;
    logic accept;
    logic measOk;
    logic [15:0] runState;

    soil_rd_if rdBus();

    // ----------------------------------------------------------------
    // request screening
    // ----------------------------------------------------------------
    assign accept = reqValid && reqReady;
    assign endAddr = {1'b0, reqStart} + {1'b0, reqCount};
    assign measOk = (opMode == soil_pkg::SOIL_MODE_NORMAL) || (opMode == soil_pkg::SOIL_MODE_SERVICE);
    assign runState = {14'h0000, opMode};

    // terminal mode serves nothing; quantity before address
    always_comb begin
        if (terminalMode) begin
            reqCheck = soil_pkg::EXC_BUSY;
        end else if (reqCount == 16'h0000 || reqCount > soil_pkg::MAX_QUANTITY) begin
            reqCheck = soil_pkg::EXC_ILLEGAL_VALUE;
        end else if (endAddr > soil_pkg::BANK_WORDS) begin
            reqCheck = soil_pkg::EXC_ILLEGAL_ADDRESS;
        end else begin
            reqCheck = soil_pkg::EXC_NONE;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SOIL_IDLE: begin
                if (accept) begin
                    state_d = (reqCheck == soil_pkg::EXC_NONE) ? SOIL_LOAD : SOIL_EXC;
                end
            end
            SOIL_LOAD: begin
                state_d = SOIL_SEND;
            end
            SOIL_SEND: begin
                if (rspReady) begin
                    state_d = last_q ? SOIL_IDLE : SOIL_LOAD;
                end
            end
            SOIL_EXC: begin
                if (rspReady) begin
                    state_d = SOIL_IDLE;
                end
            end
            default: begin
                state_d = SOIL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SOIL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // word pointer and count of words still owed
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= 16'h0000;
            remain_q <= 16'h0000;
        end else if (state_q == SOIL_IDLE && accept) begin
            addr_q <= reqStart;
            remain_q <= reqCount;
        end else if (state_q == SOIL_LOAD) begin
            addr_q <= addr_q + 16'h0001;
            remain_q <= remain_q - 16'h0001;
        end
    end

    // answer word is captured so it holds still while stalled
    always_ff @(posedge clk) begin
        if (rst) begin
            data_q <= 16'h0000;
            rspAddr_q <= 16'h0000;
            last_q <= 1'b0;
        end else if (state_q == SOIL_LOAD) begin
            data_q <= rdBus.data;
            rspAddr_q <= addr_q;
            last_q <= (remain_q == 16'h0001);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            excCode_q <= soil_pkg::EXC_NONE;
        end else if (state_q == SOIL_IDLE && accept) begin
            excCode_q <= reqCheck;
        end
    end

    // ----------------------------------------------------------------
    // dust gain, the only word that changes on its own
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            dustGain_q <= FACTORY_DUST_GAIN;
        end else if (calComplete) begin
            dustGain_q <= calGain;
        end
    end

    // ----------------------------------------------------------------
    // write attempts: acknowledged, never stored
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wrAck_q <= 1'b0;
        end else begin
            wrAck_q <= wrValid;
        end
    end

    // ----------------------------------------------------------------
    // word lookup
    // ----------------------------------------------------------------
    assign rdBus.addr = addr_q;
    assign rdBus.measOk = measOk;

    soil_word_mux #(
        .PRODUCT_KIND(PRODUCT_KIND),
        .MAP_REV(MAP_REV),
        .FW_REV(FW_REV),
        .BOARD_REV(BOARD_REV),
        .PROD_YEAR(PROD_YEAR),
        .UNIT_SERIAL(UNIT_SERIAL),
        .CAL_YEAR(CAL_YEAR),
        .CAL_MONTH(CAL_MONTH),
        .CAL_DAY(CAL_DAY)
    ) uMux (
        .rd(rdBus.server),
        .cleanA(cleanA),
        .lossA(lossA),
        .cleanB(cleanB),
        .lossB(lossB),
        .calReady(calReady),
        .calDone(calDone),
        .tiltLong(tiltLong),
        .tiltShort(tiltShort),
        .panelKelvin(panelKelvin),
        .supplyMv(supplyMv),
        .runState(runState),
        .faultWord(faultWord),
        .dustGain(dustGain_q)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reqReady = (state_q == SOIL_IDLE);
    assign rspValid = (state_q == SOIL_SEND) || (state_q == SOIL_EXC);
    assign rspData = data_q;
    assign rspAddr = rspAddr_q;
    assign rspLast = last_q || (state_q == SOIL_EXC);
    assign rspExc = (state_q == SOIL_EXC);
    assign rspExcCode = (state_q == SOIL_EXC) ? excCode_q : soil_pkg::EXC_NONE;
    assign wrAck = wrAck_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_accept_far;
        accept && !terminalMode && reqCount != 16'h0000 && reqCount <= soil_pkg::MAX_QUANTITY
            && endAddr > soil_pkg::BANK_WORDS;
    endsequence

    sequence s_exc_shown(logic [7:0] code);
        rspValid && rspExc && rspExcCode == code && rspLast;
    endsequence

    property p_far_refused;
        s_accept_far |=> s_exc_shown(soil_pkg::EXC_ILLEGAL_ADDRESS);
    endproperty
    a_far_refused: assert property (p_far_refused) else $error("far read not refused");

    property p_terminal_busy;
        accept && terminalMode |=> s_exc_shown(soil_pkg::EXC_BUSY);
    endproperty
    a_terminal_busy: assert property (p_terminal_busy) else $error("terminal read served");

    property p_first_word;
        accept && reqCheck == soil_pkg::EXC_NONE |=> ##1 rspValid && !rspExc && rspAddr == $past(reqStart, 2);
    endproperty
    a_first_word: assert property (p_first_word) else $error("first word wrong address");

    property p_kind_word;
        rspValid && !rspExc && rspAddr == soil_pkg::OFS_PRODUCT_KIND_CODE |-> rspData == PRODUCT_KIND;
    endproperty
    a_kind_word: assert property (p_kind_word) else $error("product kind wrong");

    property p_gate_meas;
        state_q == SOIL_LOAD && !measOk && addr_q == soil_pkg::OFS_CLEANLINESS_A
            |=> rspData == soil_pkg::INVALID_MARK;
    endproperty
    a_gate_meas: assert property (p_gate_meas) else $error("measurement served out of level");

    property p_gain_hold;
        !calComplete |=> $stable(dustGain_q);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("dust gain moved without calibration");

    property p_gain_load;
        calComplete |=> dustGain_q == $past(calGain);
    endproperty
    a_gain_load: assert property (p_gain_load) else $error("dust gain not updated");

    property p_wr_ack;
        wrValid && !rsp_busy_dummy() |=> wrAck;
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write attempt not acknowledged");

    property p_last_idle;
        rspValid && rspReady && rspLast |=> reqReady [*2] or (reqReady ##1 !reqReady);
    endproperty
    a_last_idle: assert property (p_last_idle) else $error("sequencer not idle after last word");

    property p_mode_word;
        rspValid && !rspExc && rspAddr == soil_pkg::OFS_RUN_STATE |-> rspData[15:2] == 14'h0000;
    endproperty
    a_mode_word: assert property (p_mode_word) else $error("run state upper bits set");

    property p_reserved_zero;
        rspValid && !rspExc && rspAddr > 16'h0024 |-> rspData == soil_pkg::RESERVED_READ;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved word not zero");

    function automatic logic rsp_busy_dummy();
        return 1'b0;
    endfunction
endmodule // soil_regbank
`default_nettype wire

// ---- dv/soil_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module soil_master_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic reqReady,
    output var logic reqValid,
    output var logic [15:0] reqStart,
    output var logic [15:0] reqCount,
    output var logic rspReady
);
    // ----------------------------------------
    // answer side, slow mode stalls every other cycle
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rspReady <= 1'b0;
        end else begin
            rspReady <= slow ? ~rspReady : 1'b1;
        end
    end

    initial begin
        reqValid = 1'b0;
        reqStart = 16'h0000;
        reqCount = 16'h0000;
    end

    // ----------------------------------------
    // request side, held until taken
    // ----------------------------------------
    task automatic issue(input logic [15:0] s, input logic [15:0] n);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqStart <= s; // zero-based, plc number minus one
        reqCount <= n;
        while (!ok) begin
            @(negedge clk);
            ok = reqReady;
            @(posedge clk);
        end
        // released lines must not keep the old value
        reqValid <= 1'b0;
        reqStart <= ~s;
        reqCount <= ~n;
    endtask
endmodule // soil_master_model
`default_nettype wire

// ---- dv/soiling_input_register_bank_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module soiling_input_register_bank_tb_top;
    typedef struct packed {
        logic [15:0] start;
        logic [15:0] count;
        logic [1:0] mode;
        logic term;
        logic [15:0] exp;
        logic [7:0] code;
    } soil_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic reqValid, reqReady, rspValid, rspReady, rspLast, rspExc, wrAck;
    logic [15:0] reqStart, reqCount, rspData, rspAddr;
    logic [7:0] rspExcCode, codeSeen;
    logic wrValid = 1'b0;
    logic calComplete = 1'b0;
    logic terminalMode = 1'b0;
    logic [1:0] opMode = 2'h1;
    logic [15:0] wrAddr = 16'h0000, wrData = 16'h0000, calGain = 16'h0000;
    logic [15:0] cleanA = 16'h01F4, lossA = 16'hFFF6, cleanB = 16'h03F3, lossB = 16'h01F5;
    logic [15:0] calReady = 16'h0001, calDone = 16'h0002, tiltLong = 16'hF8D1, tiltShort = 16'h0708;
    logic [15:0] panelKelvin = 16'h0B9A, supplyMv = 16'h5DC0, faultWord = 16'h0000;
    logic [15:0] dataQ[$];
    logic [15:0] addrQ[$];
    int lastCnt, fails, compares;
    soil_row_s rows[31] = '{
        '{16'h0000, 16'h0001, 2'h3, 1'b0, 16'h0ABC, 8'h00}, '{16'h0001, 16'h0001, 2'h1, 1'b0, 16'h0011, 8'h00},
        '{16'h0002, 16'h0001, 2'h1, 1'b0, 16'h0022, 8'h00}, '{16'h0003, 16'h0001, 2'h1, 1'b0, 16'h0018, 8'h00},
        '{16'h0004, 16'h0001, 2'h1, 1'b0, 16'h270F, 8'h00}, '{16'h0005, 16'h0001, 2'h1, 1'b0, 16'h0003, 8'h00},
        '{16'h0006, 16'h0001, 2'h1, 1'b0, 16'h0833, 8'h00}, '{16'h0007, 16'h0001, 2'h1, 1'b0, 16'h000C, 8'h00},
        '{16'h0008, 16'h0001, 2'h1, 1'b0, 16'h001F, 8'h00}, '{16'h0009, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00},
        '{16'h0013, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00}, '{16'h0014, 16'h0001, 2'h1, 1'b0, 16'h01F4, 8'h00},
        '{16'h0014, 16'h0001, 2'h3, 1'b0, 16'h270F, 8'h00}, '{16'h0015, 16'h0001, 2'h2, 1'b0, 16'hFFF6, 8'h00},
        '{16'h0016, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00}, '{16'h0018, 16'h0001, 2'h1, 1'b0, 16'h270F, 8'h00},
        '{16'h0019, 16'h0001, 2'h1, 1'b0, 16'h270F, 8'h00}, '{16'h001A, 16'h0001, 2'h2, 1'b0, 16'h0001, 8'h00},
        '{16'h001B, 16'h0001, 2'h1, 1'b0, 16'h0002, 8'h00}, '{16'h001C, 16'h0001, 2'h3, 1'b0, 16'hF8D1, 8'h00},
        '{16'h001D, 16'h0001, 2'h1, 1'b0, 16'h0708, 8'h00}, '{16'h001E, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00},
        '{16'h001F, 16'h0001, 2'h1, 1'b0, 16'h0B9A, 8'h00}, '{16'h0020, 16'h0001, 2'h1, 1'b0, 16'h5DC0, 8'h00},
        '{16'h0021, 16'h0001, 2'h3, 1'b0, 16'h0003, 8'h00}, '{16'h0063, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00},
        '{16'h0000, 16'h0000, 2'h1, 1'b0, 16'h0000, 8'h03}, '{16'h0000, 16'h007E, 2'h1, 1'b0, 16'h0000, 8'h03},
        '{16'h0000, 16'h007D, 2'h1, 1'b0, 16'h0000, 8'h02}, '{16'h0063, 16'h0002, 2'h1, 1'b0, 16'h0000, 8'h02},
        '{16'h0000, 16'h0001, 2'h1, 1'b1, 16'h0000, 8'h06}};
    logic [15:0] burst[17] = '{16'h03F2, 16'h01F4, 16'h0000, 16'h0000, 16'h270F, 16'h270F, 16'h0000, 16'h0001,
        16'h0708, 16'hF8D1, 16'h0000, 16'h0AAC, 16'h2EE0, 16'h0002, 16'h0004, 16'h0000, 16'h03E8};

    soil_regbank #(.PROD_YEAR(16'h0018), .UNIT_SERIAL(16'h270F), .CAL_YEAR(16'h0833), .CAL_MONTH(16'h000C),
        .CAL_DAY(16'h001F)) dut_u (.clk, .rst, .reqValid, .reqReady, .reqStart, .reqCount, .rspValid, .rspReady,
        .rspData, .rspAddr, .rspLast, .rspExc, .rspExcCode, .wrValid, .wrAddr, .wrData, .wrAck, .opMode,
        .terminalMode, .cleanA, .lossA, .cleanB, .lossB, .calReady, .calDone, .tiltLong, .tiltShort,
        .panelKelvin, .supplyMv, .faultWord, .calComplete, .calGain);
    soil_master_model partner_u (.clk, .rst, .slow, .reqReady, .reqValid, .reqStart, .reqCount, .rspReady);

    initial begin
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // answer capture, sampled mid-cycle to stay clear of edge races
    // ----------------------------------------
    always @(negedge clk) begin
        if (rspValid === 1'b1 && rspReady === 1'b1) begin
            dataQ.push_back(rspData);
            addrQ.push_back(rspAddr);
            codeSeen = rspExcCode;
            if (rspLast === 1'b1) lastCnt++;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input soil_row_s r);
        int n;
        n = 0;
        @(posedge clk);
        opMode <= r.mode;
        terminalMode <= r.term;
        dataQ.delete();
        addrQ.delete();
        lastCnt = 0;
        codeSeen = 8'hFF;
        partner_u.issue(r.start, r.count);
        while (lastCnt == 0 && n < 500) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic reset_run(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("ready", {15'h0000, reqReady}, 16'h0001);
        check("valid", {15'h0000, rspValid}, 16'h0000);
        check("ack", {15'h0000, wrAck}, 16'h0000);
    endtask

    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_run(6);
        foreach (rows[i]) begin
            rd(rows[i]);
            check("code", {8'h00, codeSeen}, {8'h00, rows[i].code});
            check("beats", 16'(dataQ.size()), 16'h0001);
            if (rows[i].code == 8'h00) check("word", dataQ[0], rows[i].exp);
        end
        // boundary values of every live input, consumer stalling
        @(posedge clk);
        slow <= 1'b1;
        {cleanA, lossA, cleanB, lossB} <= {16'h03F2, 16'h01F4, 16'h01F3, 16'hFFF5};
        {calReady, calDone, tiltLong, tiltShort} <= {16'h0000, 16'h0001, 16'h0708, 16'hF8D1};
        {panelKelvin, supplyMv, faultWord} <= {16'h0AAC, 16'h2EE0, 16'h0004};
        rd('{16'h0014, 16'h0011, 2'h2, 1'b0, 16'h0000, 8'h00});
        foreach (burst[i]) begin
            check("burst word", dataQ[i], burst[i]);
            check("burst addr", addrQ[i], 16'h0014 + 16'(i));
        end
        check("last flags", 16'(lastCnt), 16'h0001);
        @(posedge clk);
        {wrValid, wrAddr, wrData} <= {1'b1, 16'h0000, 16'h5A5A};
        @(posedge clk);
        {wrValid, wrAddr, wrData} <= {1'b0, 16'hFFFF, 16'hA5A5};
        @(negedge clk);
        check("write ack", {15'h0000, wrAck}, 16'h0001);
        @(negedge clk);
        check("ack drop", {15'h0000, wrAck}, 16'h0000);
        rd(rows[1]);
        check("kept", dataQ[0], 16'h0011);
        @(posedge clk);
        {calComplete, calGain} <= {1'b1, 16'h04D2};
        @(posedge clk);
        {calComplete, calGain} <= {1'b0, 16'hFB2D};
        rd('{16'h0024, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00});
        check("new gain", dataQ[0], 16'h04D2);
        reset_run(2);
        rd('{16'h0024, 16'h0001, 2'h1, 1'b0, 16'h0000, 8'h00});
        check("factory gain", dataQ[0], 16'h03E8);
        close_out();
    end
endmodule // soiling_input_register_bank_tb_top
`default_nettype wire
